// ==== design/shr_int_osc.sv ====
// internal refresh oscillator, a divider of the system clock
`timescale 1ns/1ps
`default_nettype none
module shr_int_osc #(
   parameter int HALF_CYCLES = shr_pkg::OSC_HALF_CYCLES
) (
   input  wire logic  clk_sys,
   input  wire logic  rst_b,
   shr_osc_if.drv     osc
);

   logic [shr_pkg::OSC_CNT_W-1:0] cnt;
   logic                          level;
   wire                           half_done;

   assign half_done = (cnt == shr_pkg::OSC_CNT_W'(HALF_CYCLES - 1));

   // starts high so nothing is refreshed before the first falling edge
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt   <= '0;
         level <= 1'b1;
      end else if (half_done) begin
         cnt   <= '0;
         level <= ~level;
      end else begin
         cnt   <= cnt + shr_pkg::OSC_CNT_W'(1);
      end
   end

   assign osc.level = level;

endmodule : shr_int_osc
`default_nettype wire

// ==== design/shr_refresh_sequencer.sv ====
// refresh sequencer stepping the sample-and-hold switches of ten channels
//
// Notes on behaviour
// - refresh timing follows whichever clock is selected, internal oscillator or external pin.
// - while the refresh clock is low both switches of the served channel are closed.
// - while the refresh clock is high all switches stay open and the hold capacitor holds.
// - each channel is revisited once every ten refresh clock cycles in round-robin order.
// - a newly written code reaches its output within ten refresh clock cycles, at once if its channel is being refreshed.
// - a channel refresh starts at a falling edge and the next channel one cycle later.
// - after reset the internal oscillator runs and the clock pin is not driven.
// - the clock source bit selects external mode when one and internal mode when zero.
// - in internal mode the oscillator runs near 21 kHz and is driven out on the clock pin once a control word has selected internal mode.
`timescale 1ns/1ps
`default_nettype none
module shr_refresh_sequencer #(
   parameter int OSC_HALF_CYCLES = shr_pkg::OSC_HALF_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        prog_wr,
   input  wire logic        prog_source_select,
   input  wire logic [3:0]  prog_channel,
   input  wire logic [9:0]  prog_data,
   input  wire logic        refresh_clock_pin_in,
   output var  logic        refresh_clock_pin_out,
   output var  logic        refresh_clock_pin_oe_b,
   output var  logic [9:0]  input_refresh_switch,
   output var  logic [9:0]  output_refresh_switch,
   output var  logic [9:0]  dac_code,
   output var  logic [3:0]  active_channel,
   output var  logic        refresh_start,
   output var  logic        ext_pulse_short
);

   // ******************************************************************
   // helpers
   // ******************************************************************
   function automatic logic [3:0] shr_ptr_step(input logic [3:0] p);
      if (p >= shr_pkg::PTR_LAST) begin
         shr_ptr_step = shr_pkg::PTR_FIRST;
      end else begin
         shr_ptr_step = p + 4'h1;
      end
   endfunction : shr_ptr_step

   function automatic logic [9:0] shr_onehot(input logic [3:0] p);
      shr_onehot = shr_pkg::SW_OPEN;
      if (p <= shr_pkg::PTR_LAST) begin
         shr_onehot[p] = 1'b1;
      end
   endfunction : shr_onehot

   // ******************************************************************
   // internal oscillator
   // ******************************************************************
   shr_osc_if osc_bus ();

   shr_int_osc #(
      .HALF_CYCLES (OSC_HALF_CYCLES)
   ) u_osc (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .osc     (osc_bus.drv)
   );

   // ******************************************************************
   // state
   // ******************************************************************
   logic                            clock_source_select_bit;
   logic                            programmed;
   logic                            ext_level;
   logic                            level_q;
   logic [3:0]                      ptr;
   shr_pkg::shr_phase_t             phase;
   logic [9:0]                      code_mem [0:shr_pkg::CH_COUNT-1];
   logic [shr_pkg::PULSE_CNT_W-1:0] pulse_cnt;
   logic                            ext_edge_seen;

   // ******************************************************************
   // decoding
   // ******************************************************************
   wire                      next_source;
   wire                      sel_level;
   wire                      fall_now;
   wire [3:0]                next_ptr;
   shr_pkg::shr_phase_t      next_phase;
   wire [9:0]                next_switch;
   wire                      wr_valid;
   wire                      wr_hits_next;
   wire [9:0]                next_code;
   wire                      ext_edge;
   wire                      pulse_ok;
   wire                      next_oe_b;

   // a new control word takes the source bit with it
   assign next_source = prog_wr ? prog_source_select
                                : clock_source_select_bit;

   // mode change takes effect on the cycle after the word is taken
   assign sel_level = clock_source_select_bit ? ext_level
                                              : osc_bus.level;

   assign fall_now = level_q & ~sel_level;
   assign next_ptr = fall_now ? shr_ptr_step(ptr) : ptr;

   assign next_phase = sel_level ? shr_pkg::SHR_PH_HOLD
                                 : shr_pkg::SHR_PH_REFRESH;

   assign next_switch = (next_phase == shr_pkg::SHR_PH_REFRESH)
                        ? shr_onehot(next_ptr)
                        : shr_pkg::SW_OPEN;

   // channel addresses ten to fifteen carry no channel and are dropped
   assign wr_valid     = prog_wr && (prog_channel <= shr_pkg::PTR_LAST);
   assign wr_hits_next = wr_valid && (prog_channel == next_ptr);
   // bypass so a code written during its own refresh goes out at once
   assign next_code    = wr_hits_next ? prog_data
                                      : code_mem[next_ptr];

   // pin stays released until software asks for internal mode
   assign next_oe_b = ~(programmed & ~clock_source_select_bit);

   assign ext_edge = clock_source_select_bit && (ext_level != refresh_clock_pin_in);
   assign pulse_ok = (pulse_cnt >= shr_pkg::PULSE_CNT_W'(shr_pkg::EXT_MIN_PULSE_CYCLES));

   // ******************************************************************
   // control word
   // ******************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         clock_source_select_bit <= 1'b0;
         programmed              <= 1'b0;
      end else begin
         clock_source_select_bit <= next_source;
         programmed              <= programmed | prog_wr;
      end
   end

   // ******************************************************************
   // code storage
   // ******************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < shr_pkg::CH_COUNT; i++) begin
            code_mem[i] <= shr_pkg::DATA_RESET;
         end
      end else if (wr_valid) begin
         code_mem[prog_channel] <= prog_data;
      end
   end

   // ******************************************************************
   // refresh clock and sequencing
   // ******************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ext_level <= 1'b1;
         level_q   <= 1'b1;
         ptr       <= shr_pkg::PTR_RESET;
         phase     <= shr_pkg::SHR_PH_HOLD;
      end else begin
         ext_level <= refresh_clock_pin_in;
         level_q   <= sel_level;
         ptr       <= next_ptr;
         phase     <= next_phase;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         input_refresh_switch  <= shr_pkg::SW_OPEN;
         output_refresh_switch <= shr_pkg::SW_OPEN;
         dac_code              <= shr_pkg::DATA_RESET;
         active_channel        <= shr_pkg::PTR_RESET;
         refresh_start         <= 1'b0;
      end else begin
         // both switches of a channel always move together
         input_refresh_switch  <= next_switch;
         output_refresh_switch <= next_switch;
         dac_code              <= next_code;
         active_channel        <= next_ptr;
         refresh_start         <= fall_now;
      end
   end

   // ******************************************************************
   // clock pin
   // ******************************************************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         refresh_clock_pin_out  <= 1'b1;
         refresh_clock_pin_oe_b <= 1'b1;
      end else begin
         refresh_clock_pin_out  <= osc_bus.level;
         refresh_clock_pin_oe_b <= next_oe_b;
      end
   end

   // ******************************************************************
   // external pulse width watch
   // ******************************************************************
   // only flags a short pulse; the refresh still follows the pin,
   // since dropping edges would break the ten-cycle rotation
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pulse_cnt       <= '0;
         ext_edge_seen   <= 1'b0;
         ext_pulse_short <= 1'b0;
      end else if (!clock_source_select_bit) begin
         pulse_cnt       <= '0;
         ext_edge_seen   <= 1'b0;
      end else if (ext_edge) begin
         pulse_cnt       <= '0;
         ext_edge_seen   <= 1'b1;
         if (ext_edge_seen && !pulse_ok) begin
            ext_pulse_short <= 1'b1;
         end
      end else if (!pulse_ok) begin
         pulse_cnt <= pulse_cnt + shr_pkg::PULSE_CNT_W'(1);
      end
   end

endmodule : shr_refresh_sequencer
`default_nettype wire

// ==== inc/shr_osc_if.sv ====
// carrier between the internal oscillator and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface shr_osc_if;
   logic level;

   modport drv (output level);
   modport use_side (input level);
endinterface : shr_osc_if
`default_nettype wire

// ==== inc/shr_pkg.sv ====
// shared constants and types for the sample-and-hold refresh sequencer
package shr_pkg;

   // ******************************************************************
   // system clock
   // ******************************************************************
   localparam int CLK_HZ        = 250_000_000;
   localparam int CLK_PERIOD_NS = 4;

   // ******************************************************************
   // internal refresh oscillator
   // ******************************************************************
   localparam int OSC_HZ          = 21_000;
   // half period rounded down: roughly 21 kHz, never slower
   localparam int OSC_HALF_CYCLES = CLK_HZ / (2 * OSC_HZ);
   localparam int OSC_CNT_W       = 13;

   // ******************************************************************
   // limits on the external refresh clock
   // ******************************************************************
   localparam int EXT_MAX_HZ           = 70_000;
   localparam int EXT_MIN_DUTY_PCT     = 30;
   localparam int EXT_MIN_PULSE_NS     = 4000;
   localparam int EXT_MIN_PULSE_CYCLES =
      (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CNT_W          = 10;

   // ******************************************************************
   // channels and codes
   // ******************************************************************
   localparam int         CH_COUNT   = 10;
   localparam int         PTR_W      = 4;
   localparam int         DATA_W     = 10;
   localparam logic [3:0] PTR_FIRST  = 4'h0;
   localparam logic [3:0] PTR_LAST   = 4'h9;
   localparam logic [3:0] PTR_RESET  = 4'h9;
   localparam logic [9:0] DATA_RESET = 10'h000;
   localparam logic [9:0] SW_OPEN    = 10'h000;

   // ******************************************************************
   // refresh phase
   // ******************************************************************
   typedef enum logic [1:0] {
      SHR_PH_HOLD    = 2'b01,
      SHR_PH_REFRESH = 2'b10
   } shr_phase_t;

endpackage : shr_pkg

// ==== verification/shr_ext_clk_model.sv ====
// external refresh clock source
`timescale 1ns/1ps
`default_nettype none
module shr_ext_clk_model (
   input  wire logic clk_sys,
   input  wire logic en,
   input  var  int   lo_cyc,
   input  var  int   hi_cyc,
   output var  logic level
);
   int   cnt = 0;
   logic lvl = 1'b1;
   // one driver for the port: the process owns lvl, the port follows it
   assign level = lvl;
   always @(posedge clk_sys) begin
      if (!en) begin
         // released: the board pull-up holds the pin high
         lvl <= 1'b1;
         cnt <= 0;
      end else if (cnt >= (lvl ? hi_cyc : lo_cyc) - 1) begin
         // rise placed late, clear of load steps
         lvl <= !lvl;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : shr_ext_clk_model
`default_nettype wire

// ==== verification/shr_seq_props.sv ====
// port assertions for the refresh sequencer
`timescale 1ns/1ps
`default_nettype none
module shr_seq_props #(
   parameter int OSC_HALF_CYCLES = 8
) (
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic       prog_wr,
   input wire logic       prog_source_select,
   input wire logic       refresh_clock_pin_in,
   input wire logic       refresh_clock_pin_oe_b,
   input wire logic [9:0] input_refresh_switch,
   input wire logic [9:0] output_refresh_switch,
   input wire logic [3:0] active_channel,
   input wire logic       refresh_start
);
   // ****************************************
   // helpers
   // ****************************************
   int         gap;
   logic [1:0] n_int;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // the first gaps after a mode change are short, so skip two starts
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gap   <= 0;
         n_int <= 2'h0;
      end else begin
         gap   <= refresh_start ? 0 : gap + 1;
         n_int <= refresh_clock_pin_oe_b ? 2'h0 :
                  (refresh_start && n_int != 2'h3) ? n_int + 2'h1 : n_int;
      end
   end
   sw_pair_a: assert property (input_refresh_switch == output_refresh_switch)
      else $error("switch pair differs");
   sw_one_a: assert property (|input_refresh_switch |->
      input_refresh_switch == (10'h001 << active_channel)) else $error("wrong switch closed");
   start_close_a: assert property (refresh_start |->
      input_refresh_switch == (10'h001 << active_channel)) else $error("start without switch");
   ptr_wrap_a: assert property (refresh_start |-> active_channel ==
      (($past(active_channel) == 4'h9) ? 4'h0 : $past(active_channel) + 4'h1))
      else $error("pointer step wrong");
   ptr_hold_a: assert property (!refresh_start |-> $stable(active_channel))
      else $error("pointer moved without start");
   ext_fall_a: assert property ($fell(refresh_clock_pin_in) && refresh_clock_pin_oe_b
      && $past(refresh_clock_pin_oe_b, 3) |-> ##[1:3] refresh_start)
      else $error("pin fall not followed");
   ext_rise_a: assert property ($rose(refresh_clock_pin_in) && refresh_clock_pin_oe_b
      && $past(refresh_clock_pin_oe_b, 3) |-> ##[1:3] input_refresh_switch == 10'h000)
      else $error("switches not opened");
   int_gap_a: assert property (refresh_start && n_int >= 2'h2 |->
      gap == 2 * OSC_HALF_CYCLES - 1) else $error("internal period wrong");
   drive_int_a: assert property ($fell(refresh_clock_pin_oe_b) |->
      $past(prog_wr, 2) && !$past(prog_source_select, 2)) else $error("pin driven early");
   src_ext_a: assert property (prog_wr && prog_source_select |->
      ##2 refresh_clock_pin_oe_b) else $error("pin driven in external mode");
endmodule : shr_seq_props
bind shr_refresh_sequencer shr_seq_props #(.OSC_HALF_CYCLES(OSC_HALF_CYCLES)) u_props (
   .clk_sys, .rst_b, .prog_wr, .prog_source_select, .refresh_clock_pin_in,
   .refresh_clock_pin_oe_b, .input_refresh_switch, .output_refresh_switch,
   .active_channel, .refresh_start);
`default_nettype wire

// ==== verification/test_sample_hold_refresh_sequencer.sv ====
// self-checking bench for the refresh sequencer
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_sample_hold_refresh_sequencer;
   logic       clk_sys = 1'b0;
   logic       rst_b = 1'b0;
   logic       wr = 1'b0;
   logic       src = 1'b0;
   logic [3:0] ch = 4'h0;
   logic [9:0] dat = 10'h000;
   logic       ext_en = 1'b0;
   int         lo_cyc = 2400;
   int         hi_cyc = 1200;
   logic       ext_lvl, pin_out, oe_b, start, short_p;
   logic [9:0] sw_in, sw_out, code;
   logic [3:0] chan;
   wire logic  pin = oe_b ? ext_lvl : pin_out;
   int         ptr = 9, codes[10], seed = 23, n_start = 0, cyc = 0;
   int         n_mismatch = 0, checks = 0;
   initial forever #2 clk_sys = ~clk_sys;
   shr_refresh_sequencer #(.OSC_HALF_CYCLES(8)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
      .prog_wr(wr), .prog_source_select(src), .prog_channel(ch), .prog_data(dat),
      .refresh_clock_pin_in(pin), .refresh_clock_pin_out(pin_out),
      .refresh_clock_pin_oe_b(oe_b), .input_refresh_switch(sw_in),
      .output_refresh_switch(sw_out), .dac_code(code), .active_channel(chan),
      .refresh_start(start), .ext_pulse_short(short_p));
   shr_ext_clk_model src_u (.clk_sys(clk_sys), .en(ext_en), .lo_cyc(lo_cyc),
      .hi_cyc(hi_cyc), .level(ext_lvl));
   // ****************************************
   // reference model, compared at each refresh
   // ****************************************
   always @(negedge clk_sys) begin
      if (rst_b && start === 1'b1) begin
         ptr = (ptr + 1) % 10;
         n_start++;
         `CMP(chan, 4'(ptr))
         `CMP(code, 10'(codes[ptr]))
         `CMP(sw_in, 10'h001 << ptr)
         `CMP(sw_out, 10'h001 << ptr)
         // driven pin means internal mode: a refresh starts on its fall
         if (oe_b === 1'b0) `CMP(pin_out, 1'b0)
      end
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         summarize();
      end
   end
   task automatic summarize;
      if (n_mismatch == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   task automatic do_reset;
      rst_b <= 1'b0;
      ptr = 9;
      foreach (codes[i]) codes[i] = 0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(negedge clk_sys);
      `CMP(oe_b, 1'b1)
      `CMP(sw_in, 10'h000)
      `CMP(short_p, 1'b0)
      @(posedge clk_sys);
   endtask : do_reset
   task automatic wait_start(input int n);
      int t0;
      t0 = n_start;
      wait (n_start >= t0 + n);
      @(posedge clk_sys);
   endtask : wait_start
   // codes to channels 10..15 are dropped, so the model keeps them out
   task automatic put(input logic s, input logic [3:0] c, input logic [9:0] d);
      wr  <= 1'b1;
      src <= s;
      ch  <= c;
      dat <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
      if (c < 10) codes[c] = d;
      @(negedge clk_sys);
      // a code for the channel in service goes out on the next edge
      if (c == chan) `CMP(code, d)
      @(posedge clk_sys);
   endtask : put
   task automatic burst(input logic s, input int n);
      int r;
      repeat (n) begin
         wait_start(1);
         r = $random(seed);
         put(s, r[3:0], r[13:4]);
      end
   endtask : burst
   initial begin
      do_reset();
      wait_start(3);
      `CMP(oe_b, 1'b1)
      burst(1'b0, 25);
      put(1'b0, chan, 10'h2a5);
      `CMP(oe_b, 1'b0)
      ext_en <= 1'b1;
      burst(1'b1, 8);
      `CMP(oe_b, 1'b1)
      `CMP(short_p, 1'b0)
      hi_cyc <= 500;
      wait_start(3);
      `CMP(short_p, 1'b1)
      // back to internal first, so the source's release never shows on the pin
      put(1'b0, 4'hf, 10'h3ff);
      ext_en <= 1'b0;
      burst(1'b0, 6);
      do_reset();
      burst(1'b0, 4);
      summarize();
   end
endmodule : test_sample_hold_refresh_sequencer
`default_nettype wire
